// ### hw/rcr_regs.sv
// Regulator control and status register bank: two bucks and one linear
// Function
// - Converter takes secondary voltage code while voltage choice pin is high.
// - Converter takes primary voltage code while voltage choice pin is low.
// - Control bit 7 enables the regulator; readable and writable.
// - Buck two bit 6 selects 180 degree phase offset from oscillator.
// - Buck bit 5 forces fixed-frequency PWM; zero allows light-load saving.
// - Control bits 4..2 hold the turn-on delay code, read/write.
// - Control bit 1 gates fault interrupts of that regulator.
// - Control bit 0 is read-only power-good status.
// - Linear four has one six-bit voltage code, pin independent.
// - Linear four bit 6 enables output bleed while shut down.
// - Linear four bit 5 selects low quiescent mode.
module rcr_regs
    import rcr_pkg::*;
(
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Register port behind the serial host interface
    input  wire logic [rcr_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [rcr_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [rcr_pkg::DATA_W-1:0]    reg_rdata,
    // Pins and analog status, asynchronous
    input  wire logic                          voltage_choice_pin,
    input  wire logic                          buck_two_pgood,
    input  wire logic                          buck_three_pgood,
    input  wire logic                          linear_four_pgood,
    input  wire logic                          buck_two_fault,
    input  wire logic                          buck_three_fault,
    input  wire logic                          linear_four_fault,
    // Buck two controls
    output logic                               buck_two_on,
    output logic                               buck_two_phase_shift,
    output logic                               buck_two_force_pwm,
    output logic      [rcr_pkg::DELAY_W-1:0]   buck_two_delay,
    output logic      [rcr_pkg::VCODE_W-1:0]   buck_two_vcode,
    // Buck three controls
    output logic                               buck_three_on,
    output logic                               buck_three_force_pwm,
    output logic      [rcr_pkg::DELAY_W-1:0]   buck_three_delay,
    output logic      [rcr_pkg::VCODE_W-1:0]   buck_three_vcode,
    // Linear four controls
    output logic                               linear_four_on,
    output logic                               output_bleed_active,
    output logic                               low_quiescent_select,
    output logic      [rcr_pkg::DELAY_W-1:0]   linear_four_delay,
    output logic      [rcr_pkg::VCODE_W-1:0]   linear_four_vcode,
    // Gated fault interrupt request
    output logic                               fault_irq
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [5:0] b2_main_q;
    logic [5:0] b2_alt_q;
    logic [7:0] b2_ctrl_q;
    logic [5:0] b3_main_q;
    logic [5:0] b3_alt_q;
    logic [7:0] b3_ctrl_q;
    logic [5:0] l4_volt_q;
    logic [7:0] l4_ctrl_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic       irq_q;

    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_s;

    // Writable bits of a control register; bit 0 is status only
    localparam logic [7:0] CTRL_WMASK  = 8'hfe;
    // Buck three has no phase control
    localparam logic [7:0] B3_WMASK    = 8'hbe;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Control register image: stored bits plus live power-good
    function automatic logic [7:0] ctrl_image(input logic [7:0] c,
                                              input logic       pg);
        ctrl_image = {c[7:1], pg};
    endfunction

    // Voltage register image: reserved top bits read zero
    function automatic logic [7:0] volt_image(input logic [5:0] v);
        volt_image = {2'b00, v};
    endfunction

    // Active code selection from the synchronised pin
    function automatic logic [5:0] pick_code(input logic       sel,
                                             input logic [5:0] main_v,
                                             input logic [5:0] alt_v);
        pick_code = sel ? alt_v : main_v;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    // Pin and analog comparators are not on this clock
    assign pins_async = {linear_four_fault, buck_three_fault,
                         buck_two_fault, linear_four_pgood,
                         buck_three_pgood, buck_two_pgood,
                         voltage_choice_pin};

    rcr_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (pins_async),
        .sync_out (pins_s)
    );

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            b2_main_q <= RST_VCODE;
            b2_alt_q  <= RST_VCODE;
            b3_main_q <= RST_VCODE;
            b3_alt_q  <= RST_VCODE;
            l4_volt_q <= RST_VCODE;
        end else if (reg_wr) begin
            // Top two bits of the data are dropped here
            case (reg_addr)
                OFS_BUCK_TWO_MAIN_VOLTAGE:   b2_main_q <= reg_wdata[5:0];
                OFS_BUCK_TWO_ALT_VOLTAGE:    b2_alt_q  <= reg_wdata[5:0];
                OFS_BUCK_THREE_MAIN_VOLTAGE: b3_main_q <= reg_wdata[5:0];
                OFS_BUCK_THREE_ALT_VOLTAGE:  b3_alt_q  <= reg_wdata[5:0];
                OFS_LINEAR_FOUR_VOLTAGE:     l4_volt_q <= reg_wdata[5:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            b2_ctrl_q <= RST_CTRL;
            b3_ctrl_q <= RST_CTRL;
            l4_ctrl_q <= RST_CTRL;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_BUCK_TWO_CONTROL: begin
                    b2_ctrl_q <= reg_wdata & CTRL_WMASK;
                end
                OFS_BUCK_THREE_CONTROL: begin
                    b3_ctrl_q <= reg_wdata & B3_WMASK;
                end
                OFS_LINEAR_FOUR_CONTROL: begin
                    l4_ctrl_q <= reg_wdata & CTRL_WMASK;
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            OFS_BUCK_TWO_MAIN_VOLTAGE:   rdata_d = volt_image(b2_main_q);
            OFS_BUCK_TWO_ALT_VOLTAGE:    rdata_d = volt_image(b2_alt_q);
            OFS_BUCK_TWO_CONTROL:
                rdata_d = ctrl_image(b2_ctrl_q, pins_s[LANE_PG2]);
            OFS_BUCK_THREE_MAIN_VOLTAGE: rdata_d = volt_image(b3_main_q);
            OFS_BUCK_THREE_ALT_VOLTAGE:  rdata_d = volt_image(b3_alt_q);
            OFS_BUCK_THREE_CONTROL:
                rdata_d = ctrl_image(b3_ctrl_q, pins_s[LANE_PG3]);
            OFS_LINEAR_FOUR_VOLTAGE:     rdata_d = volt_image(l4_volt_q);
            OFS_LINEAR_FOUR_CONTROL:
                rdata_d = ctrl_image(l4_ctrl_q, pins_s[LANE_PG4]);
            default:                     rdata_d = RD_UNMAPPED;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= RST_RDATA;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Regulator outputs
    // ------------------------------------------------------------
    // Registered so a pin edge cannot glitch the reference code
    always_ff @(posedge clock) begin
        if (rst) begin
            buck_two_vcode    <= RST_VCODE;
            buck_three_vcode  <= RST_VCODE;
            linear_four_vcode <= RST_VCODE;
        end else begin
            buck_two_vcode    <= pick_code(pins_s[LANE_VOLTAGE_CHOICE_PIN],
                                           b2_main_q, b2_alt_q);
            buck_three_vcode  <= pick_code(pins_s[LANE_VOLTAGE_CHOICE_PIN],
                                           b3_main_q, b3_alt_q);
            linear_four_vcode <= l4_volt_q;
        end
    end

    assign buck_two_on          = b2_ctrl_q[BIT_ON];
    assign buck_two_phase_shift = b2_ctrl_q[BIT_PHASE];
    assign buck_two_force_pwm   = b2_ctrl_q[BIT_MODE];
    assign buck_two_delay       = b2_ctrl_q[BIT_DLY_HI:BIT_DLY_LO];
    assign buck_three_on        = b3_ctrl_q[BIT_ON];
    assign buck_three_force_pwm = b3_ctrl_q[BIT_MODE];
    assign buck_three_delay     = b3_ctrl_q[BIT_DLY_HI:BIT_DLY_LO];
    assign linear_four_on       = l4_ctrl_q[BIT_ON];
    assign low_quiescent_select = l4_ctrl_q[BIT_LOWQ];
    assign linear_four_delay    = l4_ctrl_q[BIT_DLY_HI:BIT_DLY_LO];

    // Bleed only while off, never fighting an enabled output
    assign output_bleed_active  = l4_ctrl_q[BIT_BLEED] & ~l4_ctrl_q[BIT_ON];

    // ------------------------------------------------------------
    // Fault interrupt gating
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (pins_s[LANE_FLT2] & b2_ctrl_q[BIT_FIE])
                   | (pins_s[LANE_FLT3] & b3_ctrl_q[BIT_FIE])
                   | (pins_s[LANE_FLT4] & l4_ctrl_q[BIT_FIE]);
        end
    end

    assign fault_irq = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_alt_code;
        @(posedge clock) disable iff (rst)
        pins_s[LANE_VOLTAGE_CHOICE_PIN] |=> buck_two_vcode == $past(b2_alt_q);
    endproperty
    a_alt_code: assert property (p_alt_code)
        else $error("buck two not on secondary code");

    property p_main_code;
        @(posedge clock) disable iff (rst)
        !pins_s[LANE_VOLTAGE_CHOICE_PIN] |=> buck_three_vcode == $past(b3_main_q);
    endproperty
    a_main_code: assert property (p_main_code)
        else $error("buck three not on primary code");

    property p_enable_write;
        @(posedge clock) disable iff (rst)
        reg_wr && reg_addr == OFS_BUCK_TWO_CONTROL
            |=> buck_two_on == $past(reg_wdata[BIT_ON]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable bit did not follow write");

    property p_phase_write;
        @(posedge clock) disable iff (rst)
        reg_wr && reg_addr == OFS_BUCK_TWO_CONTROL
            |=> buck_two_phase_shift == $past(reg_wdata[BIT_PHASE])
                && buck_two_force_pwm == $past(reg_wdata[BIT_MODE]);
    endproperty
    a_phase_write: assert property (p_phase_write)
        else $error("phase or mode bit did not follow write");

    property p_delay_read;
        @(posedge clock) disable iff (rst)
        reg_wr && reg_addr == OFS_LINEAR_FOUR_CONTROL
            ##1 reg_rd && reg_addr == OFS_LINEAR_FOUR_CONTROL
            |=> reg_rdata[4:2] == $past(reg_wdata[4:2], 2);
    endproperty
    a_delay_read: assert property (p_delay_read)
        else $error("delay code read back wrong");

    property p_fault_gate;
        @(posedge clock) disable iff (rst)
        !b2_ctrl_q[BIT_FIE] && !b3_ctrl_q[BIT_FIE] && !l4_ctrl_q[BIT_FIE]
            |=> !fault_irq;
    endproperty
    a_fault_gate: assert property (p_fault_gate)
        else $error("fault irq raised while masked");

    property p_pgood_read;
        @(posedge clock) disable iff (rst)
        reg_rd && reg_addr == OFS_BUCK_THREE_CONTROL
            |=> reg_rdata[BIT_PGOOD] == $past(pins_s[LANE_PG3])
                && reg_rdata[BIT_PHASE] == 1'b0;
    endproperty
    a_pgood_read: assert property (p_pgood_read)
        else $error("buck three control read wrong");

    property p_bleed;
        @(posedge clock) disable iff (rst)
        output_bleed_active |-> !linear_four_on && l4_ctrl_q[BIT_BLEED];
    endproperty
    a_bleed: assert property (p_bleed)
        else $error("bleed active while regulator on");

    property p_linear_code;
        @(posedge clock) disable iff (rst)
        $changed(pins_s[LANE_VOLTAGE_CHOICE_PIN]) && $stable(l4_volt_q)
            |=> linear_four_vcode == $past(l4_volt_q);
    endproperty
    a_linear_code: assert property (p_linear_code)
        else $error("linear code moved with pin");

    property p_lowq;
        @(posedge clock) disable iff (rst)
        reg_wr && reg_addr == OFS_LINEAR_FOUR_CONTROL
            |=> low_quiescent_select == $past(reg_wdata[BIT_LOWQ]);
    endproperty
    a_lowq: assert property (p_lowq)
        else $error("low quiescent bit did not follow write");

    property p_volt_reserved;
        @(posedge clock) disable iff (rst)
        reg_rd && (reg_addr == OFS_BUCK_TWO_ALT_VOLTAGE
                   || reg_addr == OFS_LINEAR_FOUR_VOLTAGE)
            |=> reg_rdata[7:6] == 2'b00;
    endproperty
    a_volt_reserved: assert property (p_volt_reserved)
        else $error("reserved voltage bits not zero");

    property p_unmapped;
        @(posedge clock) disable iff (rst)
        reg_rd && reg_addr == 8'h33 |=> reg_rdata == RD_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule

// ### hw/rcr_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs
module rcr_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ### include/rcr_pkg.sv
// Package: register map, field positions and reset values of the regulator bank
package rcr_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 8;
    localparam int VCODE_W = 6;
    localparam int DELAY_W = 3;
    localparam int SYNC_W  = 7;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BUCK_TWO_MAIN_VOLTAGE   = 8'h30;
    localparam logic [7:0] OFS_BUCK_TWO_ALT_VOLTAGE    = 8'h31;
    localparam logic [7:0] OFS_BUCK_TWO_CONTROL        = 8'h32;
    localparam logic [7:0] OFS_BUCK_THREE_MAIN_VOLTAGE = 8'h40;
    localparam logic [7:0] OFS_BUCK_THREE_ALT_VOLTAGE  = 8'h41;
    localparam logic [7:0] OFS_BUCK_THREE_CONTROL      = 8'h42;
    localparam logic [7:0] OFS_LINEAR_FOUR_VOLTAGE     = 8'h50;
    localparam logic [7:0] OFS_LINEAR_FOUR_CONTROL     = 8'h51;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int BIT_ON      = 7;
    localparam int BIT_PHASE   = 6;
    localparam int BIT_BLEED   = 6;
    localparam int BIT_MODE    = 5;
    localparam int BIT_LOWQ    = 5;
    localparam int BIT_DLY_HI  = 4;
    localparam int BIT_DLY_LO  = 2;
    localparam int BIT_FIE     = 1;
    localparam int BIT_PGOOD   = 0;

    // ------------------------------------------------------------
    // Reset values and fixed read values
    // ------------------------------------------------------------
    localparam logic [5:0] RST_VCODE  = 6'h00;
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_RDATA  = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Synchroniser lane assignment
    localparam int LANE_VOLTAGE_CHOICE_PIN  = 0;
    localparam int LANE_PG2   = 1;
    localparam int LANE_PG3   = 2;
    localparam int LANE_PG4   = 3;
    localparam int LANE_FLT2  = 4;
    localparam int LANE_FLT3  = 5;
    localparam int LANE_FLT4  = 6;
endpackage

// ### tb/regulator_control_registers_tb.sv
// Self-checking bench for the regulator control register bank
module regulator_control_registers_tb import rcr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int TIMEOUT_CYCLES = 2000;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} rcr_row_t;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       pin = 1'b0;
    logic [2:0] pg = 3'h0;
    logic [2:0] flt = 3'h0;
    logic       b2_on, b2_ph, b2_pwm, b3_on, b3_pwm, l4_on, bleed, lowq;
    logic       fault_irq;
    logic [2:0] b2_dly, b3_dly, l4_dly;
    logic [5:0] b2_v, b3_v, l4_v;
    logic [7:0] rd_val;
    int         fail_count = 0;
    int         tests_run = 0;
    int         cycle_count = 0;
    rcr_row_t   rows [9] = '{
        '{8'h30, 8'hff, 8'h3f}, '{8'h31, 8'hff, 8'h3f},
        '{8'h32, 8'hff, 8'hfe}, '{8'h40, 8'hc5, 8'h05},
        '{8'h41, 8'hff, 8'h3f}, '{8'h42, 8'hff, 8'hbe},
        '{8'h50, 8'hff, 8'h3f}, '{8'h51, 8'hff, 8'hfe},
        '{8'h33, 8'hff, 8'h00}};

    always #25 clock = ~clock;

    rcr_regs uut (
        .clock                (clock),
        .rst                  (rst),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .voltage_choice_pin   (pin),
        .buck_two_pgood       (pg[0]),
        .buck_three_pgood     (pg[1]),
        .linear_four_pgood    (pg[2]),
        .buck_two_fault       (flt[0]),
        .buck_three_fault     (flt[1]),
        .linear_four_fault    (flt[2]),
        .buck_two_on          (b2_on),
        .buck_two_phase_shift (b2_ph),
        .buck_two_force_pwm   (b2_pwm),
        .buck_two_delay       (b2_dly),
        .buck_two_vcode       (b2_v),
        .buck_three_on        (b3_on),
        .buck_three_force_pwm (b3_pwm),
        .buck_three_delay     (b3_dly),
        .buck_three_vcode     (b3_v),
        .linear_four_on       (l4_on),
        .output_bleed_active  (bleed),
        .low_quiescent_select (lowq),
        .linear_four_delay    (l4_dly),
        .linear_four_vcode    (l4_v),
        .fault_irq            (fault_irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Every task starts and ends just after a rising edge
    // Idle edge after the strobe drops, so writes never abut
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock);
        #2;
        reg_wr = 1'b0;
        @(posedge clock);
        #2;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock);
        #2;
        reg_rd = 1'b0;
        @(posedge clock);
        #2;
        d = reg_rdata;
    endtask

    task automatic settle();
        repeat (4) @(posedge clock);
        #2;
    endtask

    always @(posedge clock) begin
        cycle_count++;
        if (cycle_count >= TIMEOUT_CYCLES) begin
            fail_count++;
            $display("unexpected timeout: expected done, seen hang");
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        #2;
        rst = 1'b0;
        // Reset value first, then write the row data (all ones except 8'hc5 at 8'h40) and read back
        foreach (rows[i]) begin
            rd(rows[i].a, rd_val);
            chk("reset value", rd_val, 8'h00);
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rd_val);
            chk("readback", rd_val, rows[i].r);
        end
        $display("register table test done");

        wr(8'h32, 8'he4);
        chk("b2 on", {7'h00, b2_on}, 8'h01);
        chk("b2 phase", {7'h00, b2_ph}, 8'h01);
        chk("b2 pwm", {7'h00, b2_pwm}, 8'h01);
        chk("b2 delay", {5'h00, b2_dly}, 8'h01);
        wr(8'h32, 8'h1a);
        chk("b2 on off", {7'h00, b2_on}, 8'h00);
        chk("b2 phase off", {7'h00, b2_ph}, 8'h00);
        chk("b2 pwm off", {7'h00, b2_pwm}, 8'h00);
        chk("b2 delay 6", {5'h00, b2_dly}, 8'h06);
        wr(8'h42, 8'hb0);
        chk("b3 on", {7'h00, b3_on}, 8'h01);
        chk("b3 pwm", {7'h00, b3_pwm}, 8'h01);
        chk("b3 delay", {5'h00, b3_dly}, 8'h04);
        wr(8'h51, 8'h6c);
        chk("l4 bleed off", {7'h00, bleed}, 8'h01);
        chk("l4 lowq", {7'h00, lowq}, 8'h01);
        chk("l4 delay", {5'h00, l4_dly}, 8'h03);
        wr(8'h51, 8'he0);
        chk("l4 on", {7'h00, l4_on}, 8'h01);
        chk("l4 bleed on", {7'h00, bleed}, 8'h00);
        $display("control output test done");

        wr(8'h30, 8'h15);
        wr(8'h31, 8'h2a);
        wr(8'h40, 8'h0b);
        wr(8'h41, 8'h34);
        wr(8'h50, 8'h27);
        settle();
        chk("b2 code low", {2'h0, b2_v}, 8'h15);
        chk("b3 code low", {2'h0, b3_v}, 8'h0b);
        chk("l4 code low", {2'h0, l4_v}, 8'h27);
        pin = 1'b1;
        settle();
        chk("b2 code high", {2'h0, b2_v}, 8'h2a);
        chk("b3 code high", {2'h0, b3_v}, 8'h34);
        chk("l4 code high", {2'h0, l4_v}, 8'h27);
        pin = 1'b0;
        settle();
        chk("b2 code back", {2'h0, b2_v}, 8'h15);
        $display("voltage choice test done");

        // Read and write in one cycle: read returns the old value
        reg_addr = 8'h31;
        reg_wdata = 8'h11;
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        @(posedge clock);
        #2;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        @(posedge clock);
        #2;
        chk("wr rd same cycle", reg_rdata, 8'h2a);
        rd(8'h31, rd_val);
        chk("after same cycle", rd_val, 8'h11);
        $display("same cycle test done");

        pg = 3'h7;
        settle();
        rd(8'h32, rd_val);
        chk("b2 pgood", rd_val, 8'h1b);
        rd(8'h42, rd_val);
        chk("b3 pgood", rd_val, 8'hb1);
        // Write then read on the very next edge
        reg_addr = 8'h51;
        reg_wdata = 8'h09;
        reg_wr = 1'b1;
        @(posedge clock);
        #2;
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(posedge clock);
        #2;
        reg_rd = 1'b0;
        @(posedge clock);
        #2;
        chk("l4 pgood", reg_rdata, 8'h09);
        $display("power good test done");

        flt = 3'h5;
        settle();
        chk("irq b2 enabled", {7'h00, fault_irq}, 8'h01);
        wr(8'h32, 8'h18);
        settle();
        chk("irq masked", {7'h00, fault_irq}, 8'h00);
        wr(8'h51, 8'h02);
        settle();
        chk("irq l4 enabled", {7'h00, fault_irq}, 8'h01);
        flt = 3'h0;
        settle();
        chk("irq fault gone", {7'h00, fault_irq}, 8'h00);
        flt = 3'h2;
        wr(8'h42, 8'h02);
        settle();
        chk("irq b3 enabled", {7'h00, fault_irq}, 8'h01);
        $display("fault interrupt test done");

        pg = 3'h0;
        rst = 1'b1;
        settle();
        rst = 1'b0;
        chk("b2 off after reset", {7'h00, b2_on}, 8'h00);
        chk("l4 code after reset", {2'h0, l4_v}, 8'h00);
        rd(8'h31, rd_val);
        chk("second reset", rd_val, 8'h00);
        $display("second reset test done");
        close_out();
    end
endmodule
